// ### common/pcd_pkg.sv
// package for the program-control decode block: register offsets, opcodes, states, carriers
// assumes an ahb-lite single-master bus at 100 MHz and one core clock
package pcd_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] pcd_off_instr   = 8'h00;
	localparam logic [7:0] pcd_off_ctrl    = 8'h04;
	localparam logic [7:0] pcd_off_pc      = 8'h08;
	localparam logic [7:0] pcd_off_wreg    = 8'h0c;
	localparam logic [7:0] pcd_off_status  = 8'h10;
	localparam logic [7:0] pcd_off_fsel    = 8'h14;
	localparam logic [7:0] pcd_off_mode    = 8'h18;
	localparam logic [7:0] pcd_off_rtc     = 8'h1c;
	localparam logic [7:0] pcd_off_wdog    = 8'h20;
	localparam logic [7:0] pcd_off_shadow  = 8'h24;
	localparam logic [7:0] pcd_off_progdat = 8'h28;
	localparam logic [7:0] pcd_off_state   = 8'h2c;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int         pcd_ctrl_turbo     = 0;
	localparam int         pcd_ctrl_skipcond  = 1;
	localparam int         pcd_ctrl_pscassign = 2;
	localparam int         pcd_state_busy     = 0;
	localparam int         pcd_state_osc      = 1;
	localparam int         pcd_state_psc      = 2;
	localparam int         pcd_st_pd          = 3;
	localparam int         pcd_st_to          = 4;
	localparam int         pcd_st_page_lo     = 5;
	localparam logic [7:0] pcd_status_rst     = 8'h18;
	localparam logic [11:0] pcd_pc_rst        = 12'hfff;

	// ************************************************************
	// instruction cycle counts, divider last count and return stack depth
	// ************************************************************
	localparam logic [2:0] pcd_cyc_one        = 3'h1;
	localparam logic [2:0] pcd_cyc_two        = 3'h2;
	localparam logic [2:0] pcd_cyc_three      = 3'h3;
	localparam logic [2:0] pcd_cyc_four       = 3'h4;
	localparam logic [1:0] pcd_div_last       = 2'h3;
	localparam int         pcd_stack_depth    = 8;

	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [11:0] pcd_no_operation_op         = 12'h000;
	localparam logic [11:0] pcd_sleep_op                = 12'h003;
	localparam logic [11:0] pcd_plain_return_op         = 12'h00c;
	localparam logic [11:0] pcd_page_return_op          = 12'h00d;
	localparam logic [11:0] pcd_interrupt_return_op     = 12'h00e;
	localparam logic [11:0] pcd_interrupt_return_add_op = 12'h00f;
	localparam logic [11:0] pcd_table_read_op           = 12'h041;
	localparam logic [3:0]  pcd_call_top4               = 4'h9;
	localparam logic [3:0]  pcd_literal_return_top4    = 4'h8;
	localparam logic [2:0]  pcd_jump_op_top3            = 3'h5;
	localparam logic [8:0]  pcd_bank_top9               = 9'h003;
	localparam logic [8:0]  pcd_page_top9               = 9'h002;
	localparam logic [6:0]  pcd_pcwrite_top7            = 7'h01;
	localparam logic [6:0]  pcd_pcadd_top7              = 7'h0f;
	localparam logic [4:0]  pcd_pc_file                 = 5'h02;
	localparam logic [2:0]  pcd_skip_top3               = 3'h3;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		pcd_idle = 2'b00,
		pcd_exec = 2'b01,
		pcd_wait = 2'b10
	} pcd_fsm_t;

	typedef struct packed {
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] fsel;
		logic [11:0] pc;
	} pcd_shadow_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} pcd_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} pcd_ahb_rsp_t;

endpackage

// ### hw/pcd_core.sv
// program-control and system-control decode and execute, with its registers on ahb-lite
// assumes a single ahb-lite master; program memory word comes back on prog_data in the same cycle as prog_addr
`timescale 1ns/1ps

module pcd_core (
	// clock and reset
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	// ahb-lite slave
	input  wire pcd_pkg::pcd_ahb_req_t ahb_req,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// program memory table port
	input  wire logic [11:0]           prog_data,
	output logic [11:0]                prog_addr,
	// core state
	output logic [11:0]                pc_out,
	output logic                       osc_running,
	output logic                       busy
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		pcd_pkg::pcd_fsm_t   fsm;
		logic [2:0]          cyc;
		logic [1:0]          div;
		logic [11:0]         instr;
		logic [11:0]         pc;
		logic [7:0]          w;
		logic [7:0]          status;
		logic [7:0]          fsel;
		logic [3:0]          mode;
		logic [7:0]          rtc;
		logic [7:0]          wdog;
		logic                psc_clr;
		logic                osc;
		logic                turbo;
		logic                skipcond;
		logic                pscassign;
		pcd_pkg::pcd_shadow_t shadow;
		logic [2:0]          sp;
		logic [95:0]         stack;
		logic [11:0]         paddr;
		logic                dph;
		logic                dwr;
		logic [7:0]          daddr;
		logic [31:0]         rdata;
	} pcd_state_t;

	pcd_state_t r;
	pcd_state_t next_r;

	logic [11:0] stack_top;
	logic [11:0] pc_inc;
	logic        go;
	logic        tick;
	logic [2:0]  cycles;
	logic        is_skip;
	logic [11:0] bus_w12;
	logic [7:0]  sum8;

	// ************************************************************
	// return stack read port
	// ************************************************************
	always_comb begin
		stack_top = 12'h000;
		for (int i = 0; i < pcd_pkg::pcd_stack_depth; i++) begin
			if (3'(i) == 3'(r.sp - 3'h1)) begin
				stack_top = r.stack[i*12 +: 12];
			end
		end
	end

	assign pc_inc  = 12'(r.pc + 12'h001);
	assign bus_w12 = ahb_req.hwdata[11:0];
	assign sum8    = 8'(r.rtc + r.w);
	assign is_skip = (r.instr[11:9] == pcd_pkg::pcd_skip_top3);

	// ************************************************************
	// cycle count for the decoded instruction
	// ************************************************************
	always_comb begin
		cycles = pcd_pkg::pcd_cyc_one;
		if ((r.instr[11:8] == pcd_pkg::pcd_call_top4) || (r.instr[11:9] == pcd_pkg::pcd_jump_op_top3)
				|| (r.instr[11:8] == pcd_pkg::pcd_literal_return_top4)
				|| ((r.instr[11:2] == 10'h003))) begin
			cycles = r.turbo ? pcd_pkg::pcd_cyc_three : pcd_pkg::pcd_cyc_two;
		end else if (r.instr == pcd_pkg::pcd_table_read_op) begin
			cycles = r.turbo ? pcd_pkg::pcd_cyc_four : pcd_pkg::pcd_cyc_one;
		end else if (((r.instr[11:5] == pcd_pkg::pcd_pcwrite_top7) || (r.instr[11:5] == pcd_pkg::pcd_pcadd_top7))
				&& (r.instr[4:0] == pcd_pkg::pcd_pc_file)) begin
			cycles = r.turbo ? pcd_pkg::pcd_cyc_three : pcd_pkg::pcd_cyc_four;
		end else if (is_skip && (r.instr[4:0] == pcd_pkg::pcd_pc_file) && (r.instr[7:5] == 3'h0)
				&& ((r.pc[0] ^ ~r.instr[8]) == 1'b1)) begin
			cycles = r.turbo ? pcd_pkg::pcd_cyc_two : pcd_pkg::pcd_cyc_four;
		end else if (is_skip) begin
			cycles = r.skipcond ? pcd_pkg::pcd_cyc_two : pcd_pkg::pcd_cyc_one;
		end
	end

	// instruction-cycle tick: every clock in turbo, one in four in compatible
	assign tick = r.turbo || (r.div == pcd_pkg::pcd_div_last);
	assign go   = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_r         = r;
		next_r.div     = 2'(r.div + 2'h1);
		next_r.psc_clr = 1'b0;
		next_r.dph     = 1'b0;

		// bus data phase: writes
		if (r.dph && r.dwr) begin
			case (r.daddr)
				pcd_pkg::pcd_off_instr: begin
					if (r.fsm == pcd_pkg::pcd_idle) begin
						next_r.instr = bus_w12;
						next_r.fsm   = pcd_pkg::pcd_exec;
						next_r.div   = 2'h0;
					end
				end
				pcd_pkg::pcd_off_ctrl: begin
					next_r.turbo     = ahb_req.hwdata[pcd_pkg::pcd_ctrl_turbo];
					next_r.skipcond  = ahb_req.hwdata[pcd_pkg::pcd_ctrl_skipcond];
					next_r.pscassign = ahb_req.hwdata[pcd_pkg::pcd_ctrl_pscassign];
				end
				pcd_pkg::pcd_off_pc:     next_r.pc     = bus_w12;
				pcd_pkg::pcd_off_wreg:   next_r.w      = ahb_req.hwdata[7:0];
				pcd_pkg::pcd_off_status: next_r.status = ahb_req.hwdata[7:0];
				pcd_pkg::pcd_off_fsel:   next_r.fsel   = ahb_req.hwdata[7:0];
				pcd_pkg::pcd_off_mode:   next_r.mode   = ahb_req.hwdata[3:0];
				pcd_pkg::pcd_off_rtc:    next_r.rtc    = ahb_req.hwdata[7:0];
				pcd_pkg::pcd_off_wdog:   next_r.wdog   = ahb_req.hwdata[7:0];
				pcd_pkg::pcd_off_shadow: next_r.shadow = (ahb_req.hwdata == 32'h0) ? '0 : {
					ahb_req.hwdata[31:24], ahb_req.hwdata[23:16], ahb_req.hwdata[15:8],
					ahb_req.hwdata[7:0], 4'h0};
				pcd_pkg::pcd_off_state:  next_r.osc    = 1'b1;
				default: ;
			endcase
		end

		// address phase capture and read data
		if (go) begin
			next_r.dph   = 1'b1;
			next_r.dwr   = ahb_req.hwrite;
			next_r.daddr = ahb_req.haddr[7:0];
			case (ahb_req.haddr[7:0])
				pcd_pkg::pcd_off_instr:   next_r.rdata = {20'h0, r.instr};
				pcd_pkg::pcd_off_ctrl:    next_r.rdata = {29'h0, r.pscassign, r.skipcond, r.turbo};
				pcd_pkg::pcd_off_pc:      next_r.rdata = {20'h0, r.pc};
				pcd_pkg::pcd_off_wreg:    next_r.rdata = {24'h0, r.w};
				pcd_pkg::pcd_off_status:  next_r.rdata = {24'h0, r.status};
				pcd_pkg::pcd_off_fsel:    next_r.rdata = {24'h0, r.fsel};
				pcd_pkg::pcd_off_mode:    next_r.rdata = {28'h0, r.mode};
				pcd_pkg::pcd_off_rtc:     next_r.rdata = {24'h0, r.rtc};
				pcd_pkg::pcd_off_wdog:    next_r.rdata = {24'h0, r.wdog};
				pcd_pkg::pcd_off_shadow:  next_r.rdata = r.shadow[35:4];
				pcd_pkg::pcd_off_progdat: next_r.rdata = {20'h0, r.paddr};
				pcd_pkg::pcd_off_state:   next_r.rdata = {29'h0, r.psc_clr, r.osc, (r.fsm != pcd_pkg::pcd_idle)};
				default:                  next_r.rdata = 32'h0;
			endcase
		end

		// execution
		case (r.fsm)
			pcd_pkg::pcd_idle: ;
			pcd_pkg::pcd_exec: begin
				next_r.fsm = pcd_pkg::pcd_wait;
				next_r.cyc = cycles;
				next_r.pc  = pc_inc;
				if (r.instr[11:8] == pcd_pkg::pcd_call_top4) begin
					next_r.stack[r.sp*12 +: 12] = pc_inc;
					next_r.sp = 3'(r.sp + 3'h1);
					next_r.pc = {r.status[7:5], 1'b0, r.instr[7:0]};
				end else if (r.instr[11:9] == pcd_pkg::pcd_jump_op_top3) begin
					next_r.pc = {r.status[7:5], r.instr[8:0]};
				end else if (r.instr[11:8] == pcd_pkg::pcd_literal_return_top4) begin
					next_r.w  = r.instr[7:0];
					next_r.pc = stack_top;
					next_r.sp = 3'(r.sp - 3'h1);
				end else begin
					case (r.instr)
						pcd_pkg::pcd_plain_return_op: begin
							next_r.pc = stack_top;
							next_r.sp = 3'(r.sp - 3'h1);
						end
						pcd_pkg::pcd_page_return_op: begin
							next_r.pc            = stack_top;
							next_r.status[7:5]   = stack_top[11:9];
							next_r.sp            = 3'(r.sp - 3'h1);
						end
						pcd_pkg::pcd_interrupt_return_op, pcd_pkg::pcd_interrupt_return_add_op: begin
							next_r.w      = r.shadow.w;
							next_r.fsel   = r.shadow.fsel;
							next_r.pc     = r.shadow.pc;
							next_r.status = {r.shadow.status[7:5], r.status[4:3], r.shadow.status[2:0]};
							if (r.instr[0]) begin
								next_r.rtc = sum8;
							end
						end
						pcd_pkg::pcd_table_read_op: begin
							next_r.paddr = {r.mode, r.w};
						end
						pcd_pkg::pcd_sleep_op: begin
							next_r.wdog                     = 8'h00;
							next_r.status[pcd_pkg::pcd_st_to] = 1'b1;
							next_r.status[pcd_pkg::pcd_st_pd] = 1'b0;
							next_r.psc_clr                  = r.pscassign;
							next_r.osc                      = 1'b0;
						end
						default: begin
							if (r.instr[11:3] == pcd_pkg::pcd_bank_top9) begin
								next_r.fsel[7:5] = r.instr[2:0];
							end else if (r.instr[11:3] == pcd_pkg::pcd_page_top9) begin
								next_r.status[7:5] = r.instr[2:0];
							end else if ((r.instr[11:5] == pcd_pkg::pcd_pcwrite_top7)
									&& (r.instr[4:0] == pcd_pkg::pcd_pc_file)) begin
								next_r.pc = {r.pc[11:8], r.w};
							end else if ((r.instr[11:5] == pcd_pkg::pcd_pcadd_top7)
									&& (r.instr[4:0] == pcd_pkg::pcd_pc_file)) begin
								next_r.pc = {r.pc[11:8], 8'(r.pc[7:0] + r.w)};
							end else if (is_skip && (cycles != pcd_pkg::pcd_cyc_one)) begin
								next_r.pc = 12'(r.pc + 12'h002);
							end
						end
					endcase
				end
			end
			pcd_pkg::pcd_wait: begin
				if ((r.instr == pcd_pkg::pcd_table_read_op) && (r.cyc == cycles)) begin
					next_r.mode = prog_data[11:8];
					next_r.w    = prog_data[7:0];
				end
				if (tick) begin
					next_r.cyc = 3'(r.cyc - 3'h1);
					if (r.cyc == pcd_pkg::pcd_cyc_one) begin
						next_r.fsm = pcd_pkg::pcd_idle;
					end
				end
			end
			default: next_r.fsm = pcd_pkg::pcd_idle;
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r        <= '0;
			r.pc     <= pcd_pkg::pcd_pc_rst;
			r.status <= pcd_pkg::pcd_status_rst;
			r.osc    <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata      = r.rdata;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign prog_addr   = r.paddr;
	assign pc_out      = r.pc;
	assign osc_running = r.osc;
	assign busy        = (r.fsm != pcd_pkg::pcd_idle);

endmodule // pcd_core

// ### tb/pcd_core_monitor.sv
// checker for pcd_core: bus response, busy, pc, table port and oscillator timing at the ports
// assumes one zero-wait bus master and the single core clock
`timescale 1ns/1ps
module pcd_core_monitor (
	// clock and reset
	input wire logic                  hclk,
	input wire logic                  hresetn,
	// bus side
	input wire pcd_pkg::pcd_ahb_req_t ahb_req,
	input wire logic [31:0]           hrdata,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	// core side
	input wire logic [11:0]           prog_data,
	input wire logic [11:0]           prog_addr,
	input wire logic [11:0]           pc_out,
	input wire logic                  osc_running,
	input wire logic                  busy
);
	logic acc;
	logic wr_d;
	assign acc = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
	// marks the data phase of an accepted write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_d <= 1'b0;
		end else begin
			wr_d <= acc & ahb_req.hwrite;
		end
	end
	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus answer not okay");
	a_busy_start: assert property (acc && ahb_req.hwrite && ahb_req.haddr[7:0] == 8'h00 && !busy |-> ##2 busy)
		else $error("busy did not follow instruction");
	a_busy_cause: assert property ($rose(busy) |-> $past(wr_d))
		else $error("busy rose without a write");
	a_busy_bound: assert property ($rose(busy) |-> ##[1:20] !busy)
		else $error("busy held too long");
	a_pc_cause: assert property ($changed(pc_out) |-> $past(busy) || $past(wr_d))
		else $error("pc moved while idle");
	a_table_addr: assert property ($changed(prog_addr) |-> $past(busy))
		else $error("table address moved while idle");
	a_osc_stop: assert property ($fell(osc_running) |-> $past(busy))
		else $error("oscillator stopped while idle");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(acc))
		else $error("read data changed without a transfer");
	a_unmapped_zero: assert property (acc && !ahb_req.hwrite && ahb_req.haddr[7:0] > 8'h2c |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // pcd_core_monitor

bind pcd_core pcd_core_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .prog_data(prog_data), .prog_addr(prog_addr), .pc_out(pc_out),
	.osc_running(osc_running), .busy(busy));

// ### tb/test_program_control_decode.sv
// bench for pcd_core: executes instructions over the bus, checks registers, pc and cycle counts
// assumes hreadyout is fed back as hready and a fixed program word on the table port
`timescale 1ns/1ps
module test_program_control_decode;
	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [7:0] ost = pcd_pkg::pcd_off_status;
	localparam logic [7:0] ow  = pcd_pkg::pcd_off_wreg;
	localparam logic [7:0] oc  = pcd_pkg::pcd_off_ctrl;
	logic                  hclk = 1'b0;
	logic                  hresetn = 1'b0;
	pcd_pkg::pcd_ahb_req_t m = '0;
	pcd_pkg::pcd_ahb_req_t req;
	logic [31:0]           hrdata;
	logic                  hreadyout;
	logic                  hresp;
	logic [11:0]           prog_data = 12'h7c4;
	logic [11:0]           prog_addr;
	logic [11:0]           pc_out;
	logic                  osc_running;
	logic                  busy;
	logic [31:0]           rd;
	int                    num_errors = 0;
	int                    cmp_count = 0;
	always #5 hclk = ~hclk;
	always_comb begin
		req = m;
		req.hready = hreadyout;
	end
	pcd_core dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .prog_data(prog_data), .prog_addr(prog_addr), .pc_out(pc_out),
		.osc_running(osc_running), .busy(busy));
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic complete_run();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 50) begin
				num_errors++;
				complete_run();
			end
		end while (hreadyout !== 1'b1);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		m.hsel <= 1'b1;
		m.haddr <= {24'h0, a};
		m.htrans <= 2'b10;
		m.hwrite <= w;
		m.hsize <= 3'b010;
		rdy();
		m.htrans <= 2'b00;
		m.hwdata <= d;
		rdy();
		rd = hrdata;
	endtask
	task automatic chkr(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// issue one instruction, count its busy cycles, then read back the pc
	task automatic run(input logic [11:0] op, input logic [31:0] cyc, input logic [11:0] pc);
		logic [31:0] n;
		xfer(1'b1, pcd_pkg::pcd_off_instr, {20'h0, op});
		n = 0;
		@(negedge hclk);
		while (busy === 1'b1) begin
			n++;
			if (n > 40) begin
				num_errors++;
				complete_run();
			end
			@(negedge hclk);
		end
		@(posedge hclk);
		chk(n, cyc);
		chkr(pcd_pkg::pcd_off_pc, {20'h0, pc});
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		chkr(pcd_pkg::pcd_off_pc, 32'hfff);
		chkr(ost, 32'h18);
		xfer(1'b1, 8'h30, 32'h5);
		chkr(8'h30, 32'h0);
		xfer(1'b1, oc, 32'h1);
		run(12'h015, 2, 12'h000);
		chkr(ost, 32'hb8);
		run(12'hb23, 4, 12'hb23);
		run(12'h012, 2, 12'hb24);
		run(12'h940, 4, 12'h440);
		run(12'h950, 4, 12'h450);
		run(12'h8a5, 4, 12'h441);
		chkr(ow, 32'ha5);
		run(12'h00c, 4, 12'hb25);
		chkr(ost, 32'h58);
		run(12'h017, 2, 12'hb26);
		run(12'h910, 4, 12'he10);
		run(12'h011, 2, 12'he11);
		run(12'h00d, 4, 12'hb27);
		chkr(ost, 32'hb8);
		run(12'h01e, 2, 12'hb28);
		chkr(pcd_pkg::pcd_off_fsel, 32'hc0);
		run(12'h000, 2, 12'hb29);
		xfer(1'b1, pcd_pkg::pcd_off_mode, 32'h3);
		xfer(1'b1, ow, 32'h21);
		run(12'h041, 5, 12'hb2a);
		chk({20'h0, prog_addr}, 32'h321);
		chkr(pcd_pkg::pcd_off_mode, 32'h7);
		chkr(ow, 32'hc4);
		run(12'h703, 2, 12'hb2b);
		xfer(1'b1, oc, 32'h3);
		run(12'h703, 3, 12'hb2d);
		xfer(1'b1, oc, 32'h1);
		run(12'h702, 3, 12'hb2f);
		xfer(1'b1, ow, 32'h66);
		run(12'h022, 4, 12'hb66);
		run(12'h1e2, 4, 12'hbcc);
		xfer(1'b1, oc, 32'h0);
		run(12'h602, 16, 12'hbce);
		run(12'h022, 16, 12'hb66);
		run(12'hb23, 8, 12'hb23);
		xfer(1'b1, oc, 32'h1);
		xfer(1'b1, pcd_pkg::pcd_off_shadow, 32'h3ce7559a);
		run(12'h00e, 4, 12'h9a0);
		chkr(ow, 32'h3c);
		chkr(ost, 32'hff);
		chkr(pcd_pkg::pcd_off_fsel, 32'h55);
		xfer(1'b1, ow, 32'h20);
		xfer(1'b1, pcd_pkg::pcd_off_rtc, 32'h10);
		xfer(1'b1, pcd_pkg::pcd_off_shadow, 32'h20001112);
		run(12'h00f, 4, 12'h120);
		chkr(pcd_pkg::pcd_off_rtc, 32'h30);
		chkr(ost, 32'h18);
		xfer(1'b1, oc, 32'h5);
		xfer(1'b1, pcd_pkg::pcd_off_wdog, 32'h5a);
		run(12'h003, 2, 12'h121);
		chk({31'h0, osc_running}, 32'h0);
		chkr(ost, 32'h10);
		chkr(pcd_pkg::pcd_off_wdog, 32'h0);
		chkr(pcd_pkg::pcd_off_state, 32'h0);
		xfer(1'b1, pcd_pkg::pcd_off_state, 32'h0);
		@(negedge hclk);
		chk({31'h0, osc_running}, 32'h1);
		chkr(pcd_pkg::pcd_off_state, 32'h2);
		complete_run();
	end
endmodule // test_program_control_decode
